//--- rtl/dbgj_if.sv
// link between the debug probe and the target: test clock, mode, data in/out and
// the open-drain reset line. assumes weak pull-ups on tdo and the reset line.
`timescale 1ns/1ps
`default_nettype none
interface dbgj_if;
  logic tck;
  logic tms;
  logic tdi;
  logic tdoOut;
  logic tdoOeN;
  logic tdo;
  logic resetOut;
  logic resetOeN;
  logic resetN;

  // ==========================================================================
  // wire levels: undriven lines float high through the pull-ups
  assign tdo = tdoOeN ? 1'b1 : tdoOut;
  assign resetN = resetOeN ? 1'b1 : resetOut;

  modport probe (output tck, output tms, output tdi, output resetOut, output resetOeN,
                 input tdo, input resetN);
  modport target (input tck, input tms, input tdi, input resetN,
                  output tdoOut, output tdoOeN);
endinterface
`default_nettype wire

//--- rtl/dbgj_pkg.sv
// shared constants for the debug halt and test-port link: frame layout, opcodes,
// debug-visible register indices, status bit positions, reset values and timing.
// assumes both ends are compiled against this package; nothing is imported.
package dbgj_pkg;

  // ==========================================================================
  // frame layout
  localparam int FRAME_BITS = 16;
  localparam int OP_MSB = 15;
  localparam int OP_LSB = 12;
  localparam int ADR_MSB = 11;
  localparam int ADR_LSB = 8;

  // ==========================================================================
  // link commands (codes are the wire encoding)
  typedef enum logic [3:0] {
    OP_NOP = 4'h0,
    OP_HALT = 4'h1,
    OP_RUN = 4'h2,
    OP_STEP = 4'h3,
    OP_CFG = 4'h4,
    OP_RD = 4'h5,
    OP_WR = 4'h6,
    OP_OCD_SET = 4'h7,
    OP_OCD_CLR = 4'h8,
    OP_JFUSE_CLR = 4'h9
  } dbgj_op_t;

  // ==========================================================================
  // debug-visible registers
  localparam logic [3:0] ADR_TCNT_LO = 4'h0;
  localparam logic [3:0] ADR_TCNT_HI = 4'h1;
  localparam logic [3:0] ADR_STATUS = 4'h2;
  localparam logic [3:0] ADR_SERIAL = 4'h3;
  localparam logic [3:0] ADR_SPI = 4'h4;
  localparam logic [3:0] ADR_FLAGS = 4'h5;

  // status byte positions
  localparam int ST_HALTED = 0;
  localparam int ST_OCD = 1;
  localparam int ST_JTAGON = 2;
  localparam int ST_TXC = 3;
  localparam int ST_FREEZE = 4;
  localparam int ST_EXTRST = 5;
  localparam int CFG_FREEZE = 0;
  localparam int FLAG_TXC = 0;

  // ==========================================================================
  // reset values and timing
  localparam logic FUSE_JTAG_RST = 1'b1;
  localparam logic FUSE_OCD_RST = 1'b0;
  localparam int TCK_RATIO = 4;
  localparam int TCK_HALF_DEF = 8;
  localparam int CONNECT_CYC_DEF = 16;
  localparam logic [15:0] WDT_LIMIT_DEF = 16'hffff;

  // accesses that would disturb a peripheral or clear a flag
  function automatic logic isRestricted(input dbgj_op_t op, input logic [3:0] adr);
    logic r;
    r = 1'b0;
    if (op == OP_RD && (adr == ADR_SERIAL || adr == ADR_SPI)) begin
      r = 1'b1;
    end
    if (op == OP_WR && (adr == ADR_SERIAL || adr == ADR_SPI || adr == ADR_FLAGS)) begin
      r = 1'b1;
    end
    return r;
  endfunction

endpackage

//--- rtl/dbgj_probe.sv
// probe end: makes the test clock by division, holds the target reset while
// attaching, sends one command frame and one collect frame per request that is not refused.
// assumes the user port is on clk and the tdo line is asynchronous.
`timescale 1ns/1ps
`default_nettype none
module dbgj_probe #(
  parameter int TCK_HALF = dbgj_pkg::TCK_HALF_DEF,
  parameter int CONNECT_CYC = dbgj_pkg::CONNECT_CYC_DEF
) (
  input wire logic clk,
  input wire logic arst_n,
  dbgj_if.probe link,
  input wire logic connectReq,
  input wire logic disconnectReq,
  input wire logic cmdValid,
  input wire logic [3:0] cmdOp,
  input wire logic [3:0] cmdAddr,
  input wire logic [7:0] cmdData,
  output logic cmdReady,
  output logic rspValid,
  output logic rspRefused,
  output logic [15:0] rspData,
  output logic connected
);

  // ==========================================================================
  // timing: a test-clock period must exceed four target clocks
  localparam int HALF_EFF = (2 * TCK_HALF > dbgj_pkg::TCK_RATIO) ? TCK_HALF :
                            dbgj_pkg::TCK_RATIO;
  localparam logic [7:0] HALF_LAST = 8'(HALF_EFF - 1);
  localparam logic [15:0] CONN_LAST = 16'(CONNECT_CYC - 1);

  typedef enum logic [2:0] {P_IDLE, P_RSTHOLD, P_LOW, P_HIGH, P_GAP} dbgj_pst_t;
  typedef enum logic [1:0] {J_USER, J_CONN, J_DISC} dbgj_job_t;

  typedef struct packed {
    dbgj_pst_t st;
    dbgj_job_t job;
    logic [7:0] div;
    logic [15:0] cnt;
    logic [15:0] frame;
    logic [15:0] rxSh;
    logic [3:0] bitCnt;
    logic second;
    logic tck;
    logic tms;
    logic tdi;
    logic rstHold;
    logic conn;
    logic [1:0] tdoSync;
    logic [1:0] rstSync;
    logic rspV;
    logic refused;
    logic [15:0] rsp;
  } dbgj_prb_state_t;

  dbgj_prb_state_t s;
  dbgj_prb_state_t n;

  // open a frame with tck low and the first bit already on tdi
  function automatic dbgj_prb_state_t startFrame(input dbgj_prb_state_t x,
                                                 input logic [15:0] f);
    dbgj_prb_state_t y;
    y = x;
    y.frame = f;
    y.tdi = f[15];
    y.tms = 1'b1;
    y.tck = 1'b0;
    y.div = 8'h00;
    y.bitCnt = 4'h0;
    y.st = P_LOW;
    return y;
  endfunction

  // ==========================================================================
  // next-state logic
  always_comb begin
    logic halfDone;
    halfDone = (s.div == HALF_LAST);
    n = s;
    n.rspV = 1'b0;
    n.refused = 1'b0;
    n.tdoSync = {s.tdoSync[0], link.tdo};
    n.rstSync = {s.rstSync[0], link.resetN};
    n.div = halfDone ? 8'h00 : s.div + 8'h01;
    unique case (s.st)
      P_IDLE: begin
        n.div = 8'h00;
        n.second = 1'b0;
        if (connectReq && !s.conn) begin
          // hold the target in reset so a firmware disable cannot block us
          n.rstHold = 1'b1;
          n.cnt = 16'h0000;
          n.job = J_CONN;
          n.st = P_RSTHOLD;
        end else if (disconnectReq && s.conn) begin
          n.job = J_DISC;
          n = startFrame(n, {dbgj_pkg::OP_OCD_CLR, 12'h000});
        end else if (cmdValid) begin
          if (dbgj_pkg::isRestricted(dbgj_pkg::dbgj_op_t'(cmdOp), cmdAddr)) begin
            n.rspV = 1'b1;
            n.refused = 1'b1;
            n.rsp = 16'h0000;
          end else begin
            n.job = J_USER;
            n = startFrame(n, {cmdOp, cmdAddr, cmdData});
          end
        end
      end
      P_RSTHOLD: begin
        n.div = 8'h00;
        if (s.cnt != CONN_LAST) begin
          n.cnt = s.cnt + 16'h0001;
        end else if (!s.rstSync[1]) begin
          n = startFrame(n, {dbgj_pkg::OP_OCD_SET, 12'h000});
        end
      end
      P_LOW: begin
        // sample the answer bit at the end of the low half
        if (halfDone) begin
          n.tck = 1'b1;
          n.rxSh = {s.rxSh[14:0], s.tdoSync[1]};
          n.st = P_HIGH;
        end
      end
      P_HIGH: begin
        if (halfDone) begin
          n.tck = 1'b0;
          if (s.bitCnt == 4'hf) begin
            n.tms = 1'b0;
            n.st = P_GAP;
          end else begin
            n.bitCnt = s.bitCnt + 4'h1;
            n.frame = {s.frame[14:0], 1'b0};
            n.tdi = s.frame[14];
            n.st = P_LOW;
          end
        end
      end
      P_GAP: begin
        if (halfDone) begin
          if (!s.second) begin
            // the answer to a frame arrives during the next one
            n = startFrame(n, {dbgj_pkg::OP_NOP, 12'h000});
            n.second = 1'b1;
          end else begin
            n.rspV = 1'b1;
            n.rsp = s.rxSh;
            n.st = P_IDLE;
            unique case (s.job)
              J_CONN: begin
                n.rstHold = 1'b0;
                n.conn = 1'b1;
              end
              J_DISC: n.conn = 1'b0;
              default: n.conn = s.conn;
            endcase
          end
        end
      end
      default: n.st = P_IDLE;
    endcase
  end

  // ==========================================================================
  // state register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s <= '0;
      s.st <= P_IDLE;
      s.job <= J_USER;
      s.tdoSync <= 2'h3;
      s.rstSync <= 2'h3;
    end else begin
      s <= n;
    end
  end

  // ==========================================================================
  // outputs
  assign cmdReady = (s.st == P_IDLE) && !connectReq && !(disconnectReq && s.conn);
  assign rspValid = s.rspV;
  assign rspRefused = s.refused;
  assign rspData = s.rsp;
  assign connected = s.conn;
  assign link.tck = s.tck;
  assign link.tms = s.tms;
  assign link.tdi = s.tdi;
  assign link.resetOut = 1'b0;
  assign link.resetOeN = ~s.rstHold;

endmodule
`default_nettype wire

//--- rtl/dbgj_target.sv
// target end: test-port slave, fuses, halt control and the freeze of watchdog
// and timer while the core is stopped. assumes link pins are asynchronous to clk
// and the core-side inputs are on clk.
//
// Notes on behaviour
// - peripherals keep running while the core halts
// - watchdog always frozen during halt
// - timer freeze selected by debugger configuration
// - running transfer completes and sets its flag
// - probe keeps test clock below quarter clk
// - port fuse defaults on, debug fuse off
// - firmware disable bit turns the port off
// - enabled port keeps its pins dedicated
// - held reset keeps port usable, core reset
// - probe holds reset while connecting
// - probe never reads clear-on-read registers
// - probe never writes write-one-clear flags
// - probe never touches serial or SPI data
// - 16-bit counter moves as two bytes
// - probe clears debug fuse when leaving
// - cleared port fuse returns only via programming; arst_n here also restores it
`timescale 1ns/1ps
`default_nettype none
module dbgj_target #(
  parameter logic [15:0] WDT_LIMIT = dbgj_pkg::WDT_LIMIT_DEF
) (
  input wire logic clk,
  input wire logic arst_n,
  dbgj_if.target link,
  input wire logic jtagDisableBit,
  input wire logic timerRun,
  input wire logic wdtKick,
  input wire logic txDone,
  input wire logic flagClr,
  input wire logic rxValid,
  input wire logic [7:0] rxByte,
  input wire logic [7:0] spiByte,
  input wire logic spiProgJtagFuse,
  output logic coreResetN,
  output logic coreHalted,
  output logic wdtCountEn,
  output logic timerCountEn,
  output logic wdtTimeout,
  output logic jtagPinsDedicated,
  output logic transmitCompleteFlag,
  output logic spiDisturb,
  output logic [15:0] timerCount
);

  // ==========================================================================
  // state
  typedef struct packed {
    logic [1:0] tckSync;
    logic [1:0] tmsSync;
    logic [1:0] tdiSync;
    logic [1:0] rstSync;
    logic tckPrev;
    logic [15:0] shIn;
    logic [3:0] bitCnt;
    logic [15:0] shOut;
    logic [15:0] rsp;
    logic halted;
    logic stepPend;
    logic freeze;
    logic fuseJtag;
    logic fuseOcd;
    logic transmit_complete_flag;
    logic [15:0] tcnt;
    logic [7:0] tmpHi;
    logic [15:0] wdt;
    logic wdtTo;
    logic [7:0] rxBuf;
    logic rxFull;
    logic spiAcc;
  } dbgj_tgt_state_t;

  dbgj_tgt_state_t s;
  dbgj_tgt_state_t n;

  logic extRst;
  logic jtagOn;
  logic haltEff;
  logic rise;
  logic fall;

  // ==========================================================================
  // port enable and halt view
  // reset line low: core held, firmware disable ignored so a probe can attach
  assign extRst = ~s.rstSync[1];
  assign jtagOn = s.fuseJtag & (extRst | ~jtagDisableBit);
  assign haltEff = s.halted & ~s.stepPend;
  assign rise = s.tckSync[1] & ~s.tckPrev;
  assign fall = ~s.tckSync[1] & s.tckPrev;

  // ==========================================================================
  // next-state logic
  always_comb begin
    logic [15:0] frm;
    logic [7:0] rdData;
    logic [7:0] stat;
    logic clrTxc;
    logic clrRx;
    dbgj_pkg::dbgj_op_t op;
    logic [3:0] adr;
    frm = '0;
    rdData = 8'h00;
    stat = 8'h00;
    clrTxc = flagClr;
    clrRx = 1'b0;
    op = dbgj_pkg::OP_NOP;
    adr = 4'h0;
    n = s;
    n.spiAcc = 1'b0;
    n.wdtTo = 1'b0;
    n.stepPend = 1'b0;

    // two-flop synchronisers on every link pin
    n.tckSync = {s.tckSync[0], link.tck};
    n.tmsSync = {s.tmsSync[0], link.tms};
    n.tdiSync = {s.tdiSync[0], link.tdi};
    n.rstSync = {s.rstSync[0], link.resetN};
    n.tckPrev = s.tckSync[1];

    // timer counts while run and out of reset, unless frozen by option during a halt
    if (timerCountEn) begin
      n.tcnt = s.tcnt + 16'h0001;
    end

    // watchdog counts only while the core really runs
    if (wdtKick || extRst) begin
      n.wdt = 16'h0000;
    end else if (wdtCountEn) begin
      if (s.wdt == WDT_LIMIT) begin
        n.wdt = 16'h0000;
        n.wdtTo = 1'b1;
      end else begin
        n.wdt = s.wdt + 16'h0001;
      end
    end

    // serial receive buffer fills regardless of halt
    if (rxValid) begin
      n.rxBuf = rxByte;
    end

    // shifter: idle reloads the answer, a frame shifts on test-clock edges
    if (!jtagOn || !s.tmsSync[1]) begin
      n.bitCnt = 4'h0;
      n.shOut = s.rsp;
    end else begin
      if (rise) begin
        frm = {s.shIn[14:0], s.tdiSync[1]};
        n.shIn = frm;
        n.bitCnt = s.bitCnt + 4'h1;
        if (s.bitCnt == 4'hf) begin
          op = dbgj_pkg::dbgj_op_t'(frm[dbgj_pkg::OP_MSB:dbgj_pkg::OP_LSB]);
          adr = frm[dbgj_pkg::ADR_MSB:dbgj_pkg::ADR_LSB];
          // halt, step, config, read and write work only with the debug fuse programmed
          unique case (op)
            dbgj_pkg::OP_HALT: n.halted = s.fuseOcd;
            dbgj_pkg::OP_RUN: n.halted = 1'b0;
            dbgj_pkg::OP_STEP: n.stepPend = s.halted & s.fuseOcd;
            dbgj_pkg::OP_CFG: begin
              if (s.fuseOcd) begin
                n.freeze = frm[dbgj_pkg::CFG_FREEZE];
              end
            end
            dbgj_pkg::OP_RD: begin
              if (s.fuseOcd) begin
                unique case (adr)
                  dbgj_pkg::ADR_TCNT_LO: begin
                    // low byte read latches the high byte for the next access
                    rdData = s.tcnt[7:0];
                    n.tmpHi = s.tcnt[15:8];
                  end
                  dbgj_pkg::ADR_TCNT_HI: rdData = s.tmpHi;
                  dbgj_pkg::ADR_SERIAL: begin
                    // reading the buffer consumes it, as a core read would
                    rdData = s.rxBuf;
                    clrRx = 1'b1;
                  end
                  dbgj_pkg::ADR_SPI: begin
                    rdData = spiByte;
                    n.spiAcc = 1'b1;
                  end
                  dbgj_pkg::ADR_FLAGS: rdData = {7'h00, s.transmit_complete_flag};
                  default: rdData = 8'h00;
                endcase
              end
            end
            dbgj_pkg::OP_WR: begin
              if (s.fuseOcd) begin
                unique case (adr)
                  dbgj_pkg::ADR_TCNT_HI: n.tmpHi = frm[7:0];
                  dbgj_pkg::ADR_TCNT_LO: n.tcnt = {s.tmpHi, frm[7:0]};
                  dbgj_pkg::ADR_FLAGS: clrTxc = clrTxc | frm[dbgj_pkg::FLAG_TXC];
                  dbgj_pkg::ADR_SPI: n.spiAcc = 1'b1;
                  default: n.spiAcc = s.spiAcc & 1'b0;
                endcase
              end
            end
            dbgj_pkg::OP_OCD_SET: n.fuseOcd = 1'b1;
            dbgj_pkg::OP_OCD_CLR: n.fuseOcd = 1'b0;
            dbgj_pkg::OP_JFUSE_CLR: n.fuseJtag = 1'b0;
            default: n.halted = s.halted;
          endcase
        end
      end
      if (fall) begin
        n.shOut = {s.shOut[14:0], 1'b0};
      end
    end

    // core held in reset cannot stay halted
    if (extRst) begin
      n.halted = 1'b0;
      n.stepPend = 1'b0;
    end

    // only the programming path or arst_n brings the port fuse back
    if (spiProgJtagFuse) begin
      n.fuseJtag = 1'b1;
    end

    // flags: a new event wins over a clear in the same cycle
    n.transmit_complete_flag = txDone | (s.transmit_complete_flag & ~clrTxc);
    n.rxFull = rxValid | (s.rxFull & ~clrRx);

    // answer word: status byte then read data
    stat[dbgj_pkg::ST_HALTED] = n.halted;
    stat[dbgj_pkg::ST_OCD] = n.fuseOcd;
    stat[dbgj_pkg::ST_JTAGON] = jtagOn;
    stat[dbgj_pkg::ST_TXC] = n.transmit_complete_flag;
    stat[dbgj_pkg::ST_FREEZE] = n.freeze;
    stat[dbgj_pkg::ST_EXTRST] = extRst;
    if (rise && s.bitCnt == 4'hf && jtagOn && s.tmsSync[1]) begin
      n.rsp = {stat, rdData};
    end
  end

  // ==========================================================================
  // state register; fuses take their shipped values at reset
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s <= '0;
      s.tckSync <= 2'h0;
      s.rstSync <= 2'h3;
      s.fuseJtag <= dbgj_pkg::FUSE_JTAG_RST;
      s.fuseOcd <= dbgj_pkg::FUSE_OCD_RST;
    end else begin
      s <= n;
    end
  end

  // ==========================================================================
  // outputs
  // peripherals other than timer and watchdog never see the halt at all
  assign coreResetN = ~extRst;
  assign coreHalted = haltEff;
  assign wdtCountEn = ~haltEff & ~extRst;
  assign timerCountEn = timerRun & ~extRst & ~(haltEff & s.freeze);
  assign wdtTimeout = s.wdtTo;
  assign jtagPinsDedicated = jtagOn;
  assign transmitCompleteFlag = s.transmit_complete_flag;
  assign spiDisturb = s.spiAcc;
  assign timerCount = s.tcnt;
  assign link.tdoOut = s.shOut[15];
  assign link.tdoOeN = ~jtagOn;

endmodule
`default_nettype wire

//--- tb/dbgj_monitor.sv
// link wire checker: test clock phases, framing and the reset line.
// assumes the bench feeds it clk, arst_n and the link signals directly.
`timescale 1ns/1ps
`default_nettype none
module dbgj_monitor (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic tdoOeN,
  input wire logic resetOut,
  input wire logic resetOeN,
  input wire logic resetN
);
  // ==========================================================================
  // helper: test clock rises counted inside the current frame
  logic tckQ_ff;
  logic [4:0] riseCnt_ff;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tckQ_ff <= 1'b0;
      riseCnt_ff <= 5'h00;
    end else begin
      tckQ_ff <= tck;
      if (!tms) begin
        riseCnt_ff <= 5'h00;
      end else if (tck && !tckQ_ff) begin
        riseCnt_ff <= riseCnt_ff + 5'h01;
      end
    end
  end

  // ==========================================================================
  // properties; each test clock phase is required to span four clocks or more
  default clocking mon_cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  tck_high_a: assert property ($rose(tck) |-> tck [*4])
    else $error("test clock high phase too short");
  tck_low_a: assert property ($fell(tck) |-> !tck [*4])
    else $error("test clock low phase too short");
  tdi_hold_a: assert property (tck && $past(tck) |-> $stable(tdi))
    else $error("data in moved while clock high");
  idle_clock_a: assert property (!tms |-> !tck)
    else $error("test clock moved outside a frame");
  frame_bits_a: assert property ($fell(tms) |-> riseCnt_ff == 5'h10)
    else $error("frame without sixteen rises");
  frame_len_a: assert property ($rose(tms) |-> ##[200:400] $fell(tms))
    else $error("frame did not end in time");
  rst_low_only_a: assert property (resetOut == 1'b0)
    else $error("reset line driven high");
  rst_hold_a: assert property ($fell(resetOeN) |-> !resetOeN [*4])
    else $error("reset line released too soon");
  tdo_after_rst_a: assert property ($rose(arst_n) |-> !tdoOeN)
    else $error("port not on after reset");
  reset_port_a: assert property (!resetN |-> ##[0:8] !tdoOeN)
    else $error("port off while reset line low");
endmodule
`default_nettype wire

//--- tb/tb.sv
// self-checking bench: probe and target joined by the link interface.
// assumes the package, interface and both ends are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb;
  // ==========================================================================
  // stimulus, observed outputs and tallies
  logic clk = 1'b0, arst_n = 1'b0, connectReq = 1'b0, disconnectReq = 1'b0;
  logic cmdValid = 1'b0, jtagDisableBit = 1'b0, timerRun = 1'b0, txDone = 1'b0;
  logic spiProgJtagFuse = 1'b0, wdtKick = 1'b0, flagClr = 1'b0, rxValid = 1'b0;
  logic [3:0] cmdOp = 4'h0, cmdAddr = 4'h0;
  logic [7:0] cmdData = 8'h00, rxByte = 8'h00, spiByte = 8'h00;
  logic cmdReady, rspValid, rspRefused, connected, coreResetN, coreHalted;
  logic wdtCountEn, timerCountEn, wdtTimeout, jtagPinsDedicated, txcFlag, spiDisturb;
  logic [15:0] rspData, timerCount, rsp;
  logic refused;
  int nErrors = 0, checksDone = 0, rstCnt = 0, coreRstCnt = 0, spiHits = 0, wdtHits = 0;
  int mark0, mark1;

  always #25 clk = ~clk;
  dbgj_if bus();
  dbgj_probe #(.TCK_HALF(8), .CONNECT_CYC(4)) dbgj_probe_inst (.clk(clk), .arst_n(arst_n),
    .link(bus.probe), .connectReq(connectReq), .disconnectReq(disconnectReq),
    .cmdValid(cmdValid), .cmdOp(cmdOp), .cmdAddr(cmdAddr), .cmdData(cmdData),
    .cmdReady(cmdReady), .rspValid(rspValid), .rspRefused(rspRefused), .rspData(rspData),
    .connected(connected));
  dbgj_target #(.WDT_LIMIT(16'h0010)) dbgj_target_inst (.clk(clk), .arst_n(arst_n),
    .link(bus.target), .jtagDisableBit(jtagDisableBit), .timerRun(timerRun),
    .wdtKick(wdtKick), .txDone(txDone), .flagClr(flagClr), .rxValid(rxValid),
    .rxByte(rxByte), .spiByte(spiByte), .spiProgJtagFuse(spiProgJtagFuse),
    .coreResetN(coreResetN), .coreHalted(coreHalted), .wdtCountEn(wdtCountEn),
    .timerCountEn(timerCountEn), .wdtTimeout(wdtTimeout),
    .jtagPinsDedicated(jtagPinsDedicated), .transmitCompleteFlag(txcFlag),
    .spiDisturb(spiDisturb), .timerCount(timerCount));
  dbgj_monitor dbgj_monitor_inst (.clk(clk), .arst_n(arst_n), .tck(bus.tck), .tms(bus.tms),
    .tdi(bus.tdi), .tdoOeN(bus.tdoOeN), .resetOut(bus.resetOut), .resetOeN(bus.resetOeN),
    .resetN(bus.resetN));

  // event tallies seen at each rising clock edge
  always @(posedge clk) begin
    if (bus.resetN === 1'b0) rstCnt <= rstCnt + 1;
    if (coreResetN === 1'b0) coreRstCnt <= coreRstCnt + 1;
    if (spiDisturb === 1'b1) spiHits <= spiHits + 1;
    if (wdtTimeout === 1'b1) wdtHits <= wdtHits + 1;
  end

  // ==========================================================================
  // checking and closing
  task automatic endSim();
    $display("checks %0d errors %0d", checksDone, nErrors);
    if (nErrors == 0 && checksDone > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checksDone++;
    if (seen !== exp) begin
      nErrors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic chkB(input string name, input logic seen, input logic exp);
    chk(name, {15'h0000, seen}, {15'h0000, exp});
  endtask

  // ==========================================================================
  // user-port access; outputs sampled at the falling edge where they are settled
  function automatic logic sig(input int w);
    case (w)
      0: return cmdReady;
      1: return rspValid;
      2: return connected;
      default: return !connected;
    endcase
  endfunction
  task automatic waitOn(input int w, input int lim);
    int n;
    n = 0;
    while (sig(w) !== 1'b1) begin
      @(negedge clk);
      n++;
      if (n > lim) begin
        nErrors++;
        $display("[ERR] wait%0d expected 1 seen 0", w);
        endSim();
      end
    end
  endtask
  task automatic cmd(input dbgj_pkg::dbgj_op_t op, input logic [3:0] adr, input logic [7:0] d);
    @(negedge clk);
    waitOn(0, 2000);
    @(posedge clk);
    cmdValid <= 1'b1;
    cmdOp <= op;
    cmdAddr <= adr;
    cmdData <= d;
    @(posedge clk);
    cmdValid <= 1'b0;
    @(negedge clk);
    waitOn(1, 2000);
    rsp = rspData;
    refused = rspRefused;
  endtask
  // request held until the link state flips, then dropped
  task automatic attach(input logic on);
    @(posedge clk);
    connectReq <= on;
    disconnectReq <= !on;
    @(negedge clk);
    waitOn(on ? 2 : 3, 3000);
    @(posedge clk);
    connectReq <= 1'b0;
    disconnectReq <= 1'b0;
  endtask

  // ==========================================================================
  // scenarios
  initial begin
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    // port on, core running, watchdog counting straight after reset
    @(negedge clk);
    chkB("pins", jtagPinsDedicated, 1'b1);
    mark0 = wdtHits;
    repeat (40) @(negedge clk);
    chkB("wdtFires", wdtHits != mark0, 1'b1);
    // without the debug fuse a halt is ignored
    cmd(dbgj_pkg::OP_HALT, 4'h0, 8'h00);
    chkB("haltIgnored", coreHalted, 1'b0);
    chkB("stOcdOff", rsp[8 + dbgj_pkg::ST_OCD], 1'b0);
    chkB("stPortOn", rsp[8 + dbgj_pkg::ST_JTAGON], 1'b1);
    mark0 = rstCnt;
    mark1 = coreRstCnt;
    attach(1'b1);
    chkB("rstLine", rstCnt != mark0, 1'b1);
    chkB("coreRst", coreRstCnt != mark1, 1'b1);
    cmd(dbgj_pkg::OP_NOP, 4'h0, 8'h00);
    chkB("stOcdOn", rsp[8 + dbgj_pkg::ST_OCD], 1'b1);
    // halt with timer freeze selected gates both counters
    @(posedge clk);
    timerRun <= 1'b1;
    cmd(dbgj_pkg::OP_CFG, 4'h0, 8'h01);
    cmd(dbgj_pkg::OP_HALT, 4'h0, 8'h00);
    chkB("halted", coreHalted, 1'b1);
    chkB("wdtGated", wdtCountEn, 1'b0);
    chkB("timerGated", timerCountEn, 1'b0);
    chkB("stFreeze", rsp[8 + dbgj_pkg::ST_FREEZE], 1'b1);
    // 16-bit timer: high byte then low commits, low read then high
    mark0 = wdtHits;
    cmd(dbgj_pkg::OP_WR, dbgj_pkg::ADR_TCNT_HI, 8'h5a);
    cmd(dbgj_pkg::OP_WR, dbgj_pkg::ADR_TCNT_LO, 8'hc3);
    repeat (100) @(negedge clk);
    chk("timerHeld", timerCount, 16'h5ac3);
    cmd(dbgj_pkg::OP_RD, dbgj_pkg::ADR_TCNT_LO, 8'h00);
    chk("rdLow", {8'h00, rsp[7:0]}, 16'h00c3);
    cmd(dbgj_pkg::OP_RD, dbgj_pkg::ADR_TCNT_HI, 8'h00);
    chk("rdHigh", {8'h00, rsp[7:0]}, 16'h005a);
    chkB("wdtFrozen", wdtHits == mark0, 1'b1);
    // a transfer ending during the halt still raises its flag
    @(posedge clk);
    txDone <= 1'b1;
    @(posedge clk);
    txDone <= 1'b0;
    @(negedge clk);
    chkB("txcSet", txcFlag, 1'b1);
    cmd(dbgj_pkg::OP_RD, dbgj_pkg::ADR_FLAGS, 8'h00);
    chkB("txcRead", rsp[dbgj_pkg::FLAG_TXC], 1'b1);
    chkB("stTxc", rsp[8 + dbgj_pkg::ST_TXC], 1'b1);
    // disturbing accesses are refused with empty data
    for (int i = 0; i < 5; i++) begin
      cmd((i < 2) ? dbgj_pkg::OP_RD : dbgj_pkg::OP_WR, (i == 4) ? dbgj_pkg::ADR_FLAGS :
          (i % 2 == 1) ? dbgj_pkg::ADR_SPI : dbgj_pkg::ADR_SERIAL, 8'hff);
      chkB("refused", refused, 1'b1);
      chk("refusedData", rsp, 16'h0000);
    end
    chkB("spiQuiet", spiHits == 0, 1'b1);
    chkB("txcKept", txcFlag, 1'b1);
    @(posedge clk);
    txDone <= 1'b1;
    flagClr <= 1'b1;
    @(posedge clk);
    txDone <= 1'b0;
    @(negedge clk);
    chkB("setWins", txcFlag, 1'b1);
    @(posedge clk);
    flagClr <= 1'b0;
    @(negedge clk);
    chkB("txcClr", txcFlag, 1'b0);
    // timer released while the core stays halted
    cmd(dbgj_pkg::OP_CFG, 4'h0, 8'h00);
    chkB("timerRuns", timerCountEn, 1'b1);
    chkB("wdtStill", wdtCountEn, 1'b0);
    chkB("timerMoved", timerCount !== 16'h5ac3, 1'b1);
    cmd(dbgj_pkg::OP_STEP, 4'h0, 8'h00);
    chkB("stepHalts", coreHalted, 1'b1);
    cmd(dbgj_pkg::OP_RUN, 4'h0, 8'h00);
    chkB("running", coreHalted, 1'b0);
    chkB("wdtBack", wdtCountEn, 1'b1);
    attach(1'b0);
    cmd(dbgj_pkg::OP_NOP, 4'h0, 8'h00);
    chkB("stOcdClr", rsp[8 + dbgj_pkg::ST_OCD], 1'b0);
    // firmware disable frees the pins; attach under reset brings the port back
    @(posedge clk);
    jtagDisableBit <= 1'b1;
    repeat (8) @(negedge clk);
    chkB("pinsFreed", jtagPinsDedicated, 1'b0);
    chkB("tdoOff", bus.tdoOeN, 1'b1);
    attach(1'b1);
    jtagDisableBit <= 1'b0; // the held core reset cleared it
    cmd(dbgj_pkg::OP_NOP, 4'h0, 8'h00);
    chk("portBack", rsp, 16'h0600);
    // cleared port fuse stays off until reprogrammed over spi
    cmd(dbgj_pkg::OP_JFUSE_CLR, 4'h0, 8'h00);
    repeat (50) @(negedge clk);
    chkB("fuseOff", jtagPinsDedicated, 1'b0);
    cmd(dbgj_pkg::OP_NOP, 4'h0, 8'h00);
    chk("deadPort", rsp, 16'hffff);
    @(posedge clk);
    spiProgJtagFuse <= 1'b1;
    @(posedge clk);
    spiProgJtagFuse <= 1'b0;
    repeat (4) @(negedge clk);
    chkB("fuseBack", jtagPinsDedicated, 1'b1);
    endSim();
  end
endmodule
`default_nettype wire
